// ==== verilog/idf_map.vh ====
`ifndef IDF_MAP_VH
`define IDF_MAP_VH

// Register offsets (byte addresses)
`define IDF_CFG_ADDR 8'h18
`define IDF_STAT_ADDR 8'h1c

// Configuration reset value
`define IDF_CFG_RST 24'h201800

// Configuration field positions
`define IDF_RATE_BIT 23
`define IDF_DLPF_HI 13
`define IDF_DLPF_LO 12
`define IDF_FCGEN_HI 11
`define IDF_FCGEN_LO 8
`define IDF_CGMON_BIT 7
`define IDF_CGMAG_HI 6
`define IDF_CGMAG_LO 4
`define IDF_PHOFF_HI 3
`define IDF_PHOFF_LO 0

// Status field positions
`define IDF_ST_FLAG_BIT 0
`define IDF_ST_MONACT_BIT 1
`define IDF_ST_PACEOK_BIT 2
`define IDF_ST_DRVACT_BIT 3
`define IDF_ST_LPF_LO 4
`define IDF_ST_MAG_LO 8
`define IDF_ST_LIMIT_BIT 11
`define IDF_ST_PHASE_LO 12

// Lowpass codes
`define IDF_LPF_BYPASS 2'h0
`define IDF_LPF_4HZ 2'h1
`define IDF_LPF_16HZ 2'h3

// Drive magnitude codes
`define IDF_MAG_OFF 3'h0
`define IDF_MAG_RESV 3'h6

// Drive frequency codes
`define IDF_FC_X4 4'h0
`define IDF_FC_OFS80K 4'h1
`define IDF_FC_OFS40K 4'h2

// Clock rates in Hz
`define IDF_CORE_HZ 64'd10000000
`define IDF_FM_32768_HZ 64'd32768
`define IDF_FM_32000_HZ 64'd32000
`define IDF_FM_31968_HZ 64'd31968

// Phase accumulator width and scale
`define IDF_ACC_W 24
`define IDF_ACC_SHIFT 24
`define IDF_PH_SHIFT 19

`endif

// ==== verilog/idf_nco.v ====
`include "idf_map.vh"

module idf_nco (
    input wire core_clk,
    input wire reset,
    input wire run,
    input wire [23:0] step,
    input wire [23:0] offset,
    output reg wave_r,
    output reg tick_r
);
    reg [23:0] acc_r;
    wire [24:0] sum;
    wire [23:0] shifted;

    assign sum = {1'b0, acc_r} + {1'b0, step};
    assign shifted = acc_r + offset;

    // Accumulator with carry tick and offset phase
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc_r <= 24'h000000;
            wave_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (run) begin
            acc_r <= sum[23:0];
            tick_r <= sum[24];
            wave_r <= shifted[23];
        end else begin
            acc_r <= 24'h000000;
            tick_r <= 1'b0;
            wave_r <= 1'b0;
        end
    end
endmodule // idf_nco

// ==== verilog/idf_drive_mon.v ====
`include "idf_map.vh"

module idf_drive_mon (
    input wire core_clk,
    input wire reset,
    input wire mon_on,
    input wire pos_fault,
    input wire neg_fault,
    input wire flag_clr,
    output reg flag_r
);
    reg fault_r;

    // Compliance watch on both drive pins
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fault_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            fault_r <= mon_on & (pos_fault | neg_fault);
            if (fault_r)
                flag_r <= 1'b1;
            else if (flag_clr)
                flag_r <= 1'b0;
        end
    end
endmodule // idf_drive_mon

// ==== verilog/idf_top.v ====
// Behaviour
// - Lowpass code 00 bypass, 01 about 4Hz, 10 about 8Hz, 11 about 16Hz.
// - Lowpass code 11 allowed only with the faster sample rate.
// - Unsupported lowpass code runs internally as the 4Hz code 01.
// - Written lowpass bits stay stored; reads return the effective code.
// - Filter cutoffs scale with the selected master clock frequency.
// - Unsupported rate and filter pairs map to the default setting.
// - Drive frequency 0000 is four times master clock; 1000 is master/64.
// - Codes 0100 to 0111 divide by 4 to 32; 1001 divides by 128.
// - Codes 101x and 11xx divide the master clock by 256.
// - Frequencies near 16k to 64k are shifted to 18k to 80k.
// - Pulse edge detection works only with drive codes 0001 or 0010.
// - Monitor enable bit activates monitor and flag when drive is active.
// - Magnitude 000 and reserved 110 float both pins; other codes set drive current.
// - Drive codes 0010 and above use four phase bits, 11.25 degree steps.
// - Drive code 0001 uses upper three phase bits, 22.5 degree steps.
// - Drive code 0000 uses upper two phase bits, 45 degree steps.
// - Master clock follows its select: 32768, 32000, 32000, 31968 Hz.
`include "idf_map.vh"

module idf_top (
    input wire core_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [23:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [1:0] master_clock_select,
    input wire channel_active,
    input wire drive_pos_fault,
    input wire drive_neg_fault,
    output reg [23:0] reg_rdata,
    output reg [1:0] lowpass_eff,
    output reg lowpass_bypass,
    output reg [2:0] drive_level,
    output reg drive_pos_pin_out,
    output reg drive_pos_pin_oe,
    output reg drive_neg_pin_out,
    output reg drive_neg_pin_oe,
    output reg demod_ref,
    output reg master_tick,
    output reg pulse_edge_ok,
    output reg drive_monitor_flag
);
    reg [23:0] cfg_r;
    reg [23:0] rdata_nxt;
    reg [15:0] mstr_step_r;
    reg [23:0] exc_step_r;
    reg [23:0] phase_word_r;
    reg exc_run_r;
    wire [1:0] dlpf_raw;
    wire rate_slow;
    wire [3:0] fcgen;
    wire [2:0] cgmag_raw;
    wire [3:0] phoff;
    wire cgmon;
    wire [1:0] dlpf_eff;
    wire [2:0] mag_eff;
    wire drive_on;
    wire mon_on;
    wire flag_clr;
    wire cfg_wr;
    wire pace_ok;
    wire mag_warn;
    wire mstr_tick;
    wire exc_wave;
    wire ref_wave;
    wire mon_flag;
    wire [23:0] status_word;

    // Master clock step per core cycle, 64-bit to avoid overflow
    function [15:0] mstr_step;
        input [1:0] sel;
        reg [63:0] hz;
        reg [63:0] st;
        begin
            case (sel)
                2'h0: hz = `IDF_FM_32768_HZ;
                2'h1: hz = `IDF_FM_32000_HZ;
                2'h2: hz = `IDF_FM_32000_HZ;
                2'h3: hz = `IDF_FM_31968_HZ;
                default: hz = `IDF_FM_32768_HZ;
            endcase
            st = (hz << `IDF_ACC_SHIFT) / `IDF_CORE_HZ;
            mstr_step = st[15:0];
        end
    endfunction

    // Excitation step as a ratio of the master clock step
    function [23:0] exc_step;
        input [3:0] code;
        input [15:0] m;
        reg [31:0] b;
        reg [31:0] r;
        begin
            b = {16'h0000, m};
            case (code)
                4'h0: r = b << 2;
                4'h1: r = (b * 32'h00000005) >> 1;
                4'h2: r = (b * 32'h00000005) >> 2;
                4'h3: r = (b * 32'h00000239) >> 10;
                4'h4: r = b >> 2;
                4'h5: r = b >> 3;
                4'h6: r = b >> 4;
                4'h7: r = b >> 5;
                4'h8: r = b >> 6;
                4'h9: r = b >> 7;
                default: r = b >> 8;
            endcase
            exc_step = r[23:0];
        end
    endfunction

    // Phase offset word, 11.25 degrees is one step of 2^19
    function [23:0] phase_word;
        input [3:0] code;
        input [3:0] ph;
        reg [3:0] used;
        begin
            case (code)
                `IDF_FC_X4: used = {ph[3:2], 2'h0};
                `IDF_FC_OFS80K: used = {ph[3:1], 1'b0};
                default: used = ph;
            endcase
            phase_word = {used, 20'h00000} >> 1;
        end
    endfunction

    // Effective lowpass code
    function [1:0] lpf_effective;
        input [1:0] raw;
        input slow;
        begin
            if (raw == `IDF_LPF_16HZ && slow)
                lpf_effective = `IDF_LPF_4HZ;
            else
                lpf_effective = raw;
        end
    endfunction

    // Pulse edge detection supported only at the offset drive codes
    function pace_supported;
        input [3:0] code;
        begin
            pace_supported = (code == `IDF_FC_OFS80K) || (code == `IDF_FC_OFS40K);
        end
    endfunction

    // Write strobe aimed at one register
    function reg_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            reg_hit = strobe && (addr == target);
        end
    endfunction

    // Magnitude above the software limit for the drive frequency
    function mag_over_limit;
        input [3:0] code;
        input [2:0] mag;
        reg [2:0] limit;
        begin
            case (code)
                4'h0: limit = 3'h7;
                4'h1: limit = 3'h7;
                4'h2: limit = 3'h7;
                4'h3: limit = 3'h7;
                4'h4: limit = 3'h6;
                4'h5: limit = 3'h3;
                4'h6: limit = 3'h2;
                4'h7: limit = 3'h1;
                default: limit = 3'h1;
            endcase
            mag_over_limit = (mag > limit);
        end
    endfunction

    // Field decode
    assign dlpf_raw = cfg_r[`IDF_DLPF_HI:`IDF_DLPF_LO];
    assign rate_slow = cfg_r[`IDF_RATE_BIT];
    assign fcgen = cfg_r[`IDF_FCGEN_HI:`IDF_FCGEN_LO];
    assign cgmag_raw = cfg_r[`IDF_CGMAG_HI:`IDF_CGMAG_LO];
    assign phoff = cfg_r[`IDF_PHOFF_HI:`IDF_PHOFF_LO];
    assign cgmon = cfg_r[`IDF_CGMON_BIT];

    assign dlpf_eff = lpf_effective(dlpf_raw, rate_slow);

    // Drive gating
    assign mag_eff = (cgmag_raw == `IDF_MAG_RESV) ? `IDF_MAG_OFF : cgmag_raw;
    assign drive_on = channel_active && (mag_eff != `IDF_MAG_OFF);
    assign mon_on = cgmon && drive_on;

    // Write decode
    assign cfg_wr = reg_hit(reg_wr, reg_addr, `IDF_CFG_ADDR);
    assign flag_clr = reg_hit(reg_wr, reg_addr, `IDF_STAT_ADDR) && reg_wdata[`IDF_ST_FLAG_BIT];

    // Pace and limit decode
    assign pace_ok = pace_supported(fcgen);
    assign mag_warn = mag_over_limit(fcgen, cgmag_raw);

    // Status word shows live state of the block
    assign status_word = {
        8'h00,
        phoff,
        mag_warn,
        mag_eff,
        2'h0,
        dlpf_eff,
        drive_on,
        pace_ok,
        mon_on,
        mon_flag
    };

    // Configuration register
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_r <= `IDF_CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= reg_wdata;
        end
    end

    // Read data mux
    always @* begin
        rdata_nxt = 24'h000000;
        if (reg_rd) begin
            case (reg_addr)
                `IDF_CFG_ADDR: begin
                    rdata_nxt = cfg_r;
                    rdata_nxt[`IDF_DLPF_HI:`IDF_DLPF_LO] = dlpf_eff;
                end
                `IDF_STAT_ADDR: begin
                    rdata_nxt = status_word;
                end
                default: begin
                    rdata_nxt = 24'h000000;
                end
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 24'h000000;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Step and phase registers follow configuration
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mstr_step_r <= 16'h0000;
            exc_step_r <= 24'h000000;
            phase_word_r <= 24'h000000;
            exc_run_r <= 1'b0;
        end else begin
            mstr_step_r <= mstr_step(master_clock_select);
            exc_step_r <= exc_step(fcgen, mstr_step_r);
            phase_word_r <= phase_word(fcgen, phoff);
            exc_run_r <= drive_on;
        end
    end

    // Master clock generator
    idf_nco u_mstr (
        .core_clk(core_clk),
        .reset(reset),
        .run(1'b1),
        .step({8'h00, mstr_step_r}),
        .offset(24'h000000),
        .wave_r(),
        .tick_r(mstr_tick)
    );

    // Excitation generator
    idf_nco u_exc (
        .core_clk(core_clk),
        .reset(reset),
        .run(exc_run_r),
        .step(exc_step_r),
        .offset(24'h000000),
        .wave_r(exc_wave),
        .tick_r()
    );

    // Phase-shifted demodulation reference, same step as excitation
    idf_nco u_ref (
        .core_clk(core_clk),
        .reset(reset),
        .run(exc_run_r),
        .step(exc_step_r),
        .offset(phase_word_r),
        .wave_r(ref_wave),
        .tick_r()
    );

    // Drive compliance monitor
    idf_drive_mon u_mon (
        .core_clk(core_clk),
        .reset(reset),
        .mon_on(mon_on),
        .pos_fault(drive_pos_fault),
        .neg_fault(drive_neg_fault),
        .flag_clr(flag_clr),
        .flag_r(mon_flag)
    );

    // Registered outputs
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lowpass_eff <= `IDF_LPF_4HZ;
            lowpass_bypass <= 1'b0;
            drive_level <= `IDF_MAG_OFF;
            drive_pos_pin_out <= 1'b0;
            drive_pos_pin_oe <= 1'b0;
            drive_neg_pin_out <= 1'b0;
            drive_neg_pin_oe <= 1'b0;
            demod_ref <= 1'b0;
            master_tick <= 1'b0;
            pulse_edge_ok <= 1'b0;
            drive_monitor_flag <= 1'b0;
        end else begin
            lowpass_eff <= dlpf_eff;
            lowpass_bypass <= (dlpf_eff == `IDF_LPF_BYPASS);
            drive_level <= drive_on ? mag_eff : `IDF_MAG_OFF;
            drive_pos_pin_out <= exc_run_r & exc_wave;
            drive_neg_pin_out <= exc_run_r & ~exc_wave;
            drive_pos_pin_oe <= exc_run_r;
            drive_neg_pin_oe <= exc_run_r;
            demod_ref <= exc_run_r & ref_wave;
            master_tick <= mstr_tick;
            pulse_edge_ok <= pace_ok;
            drive_monitor_flag <= mon_flag;
        end
    end
endmodule // idf_top

// ==== bench/idf_top_monitor.sv ====
module idf_monitor (
    input logic core_clk,
    input logic reset,
    input logic [7:0] reg_addr,
    input logic [23:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic drive_pos_fault,
    input logic drive_neg_fault,
    input logic [23:0] reg_rdata,
    input logic [1:0] lowpass_eff,
    input logic lowpass_bypass,
    input logic [2:0] drive_level,
    input logic drive_pos_pin_out,
    input logic drive_pos_pin_oe,
    input logic drive_neg_pin_out,
    input logic drive_neg_pin_oe,
    input logic master_tick,
    input logic pulse_edge_ok,
    input logic drive_monitor_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence cfg_wr;
        reg_wr && reg_addr == 8'h18;
    endsequence
    sequence lpf_bad;
        reg_wdata[23] && reg_wdata[13:12] == 2'h3;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 24'h0)
        else $error("read data not zero");
    unmapped_rd_a: assert property (reg_rd && reg_addr != 8'h18 && reg_addr != 8'h1c
        |=> reg_rdata == 24'h0) else $error("unmapped read not zero");
    bypass_code_a: assert property (lowpass_bypass == (lowpass_eff == 2'h0))
        else $error("bypass flag wrong");
    lpf_follow_a: assert property (cfg_wr ##0 !reg_wdata[23]
        |-> ##2 lowpass_eff == $past(reg_wdata[13:12], 2)) else $error("lowpass code wrong");
    lpf_remap_a: assert property (cfg_wr ##0 lpf_bad |-> ##2 lowpass_eff == 2'h1)
        else $error("lowpass remap wrong");
    pace_sel_a: assert property (cfg_wr
        |-> ##2 pulse_edge_ok == ($past(reg_wdata[11:8], 2) inside {4'h1, 4'h2}))
        else $error("pulse edge ok wrong");
    mag_off_a: assert property (cfg_wr ##0 reg_wdata[5:4] == 2'h0 &&
        reg_wdata[6] == reg_wdata[5] |-> ##2 drive_level == 3'h0
        ##1 !drive_pos_pin_oe && !drive_neg_pin_oe) else $error("drive not off");
    drive_comp_a: assert property (drive_pos_pin_oe |-> drive_neg_pin_oe &&
        drive_neg_pin_out != drive_pos_pin_out) else $error("drive pins not complementary");
    flag_hold_a: assert property (drive_monitor_flag &&
        !$past(reg_wr && reg_addr == 8'h1c && reg_wdata[0]) |=> drive_monitor_flag)
        else $error("flag dropped");
    flag_cause_a: assert property ($rose(drive_monitor_flag)
        |-> $past(drive_pos_fault || drive_neg_fault, 3)) else $error("flag without fault");
    tick_pulse_a: assert property (master_tick |=> !master_tick)
        else $error("tick longer than one cycle");
endmodule // idf_monitor

bind idf_top idf_monitor i_mon (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .drive_pos_fault(drive_pos_fault),
    .drive_neg_fault(drive_neg_fault), .reg_rdata(reg_rdata), .lowpass_eff(lowpass_eff),
    .lowpass_bypass(lowpass_bypass), .drive_level(drive_level),
    .drive_pos_pin_out(drive_pos_pin_out), .drive_pos_pin_oe(drive_pos_pin_oe),
    .drive_neg_pin_out(drive_neg_pin_out), .drive_neg_pin_oe(drive_neg_pin_oe),
    .master_tick(master_tick), .pulse_edge_ok(pulse_edge_ok),
    .drive_monitor_flag(drive_monitor_flag));

// ==== bench/idf_top_tb_top.sv ====
module idf_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wdata = 24'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] mclk_sel = 2'h0;
    logic chan_on = 1'b1;
    logic pos_f = 1'b0;
    logic neg_f = 1'b0;
    wire [23:0] rdata;
    wire [1:0] lpf;
    wire byp, p_out, p_oe, n_out, n_oe, dref, tick, pace_ok, flag;
    wire [2:0] lvl;
    int error_cnt = 0;
    int n_tests = 0;
    always #50 core_clk = ~core_clk;
    idf_top i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .master_clock_select(mclk_sel),
        .channel_active(chan_on), .drive_pos_fault(pos_f), .drive_neg_fault(neg_f),
        .reg_rdata(rdata), .lowpass_eff(lpf), .lowpass_bypass(byp), .drive_level(lvl),
        .drive_pos_pin_out(p_out), .drive_pos_pin_oe(p_oe), .drive_neg_pin_out(n_out),
        .drive_neg_pin_oe(n_oe), .demod_ref(dref), .master_tick(tick),
        .pulse_edge_ok(pace_ok), .drive_monitor_flag(flag));
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic near(input string w, input int e, input int g);
        n_tests++;
        if (g > e + 1 || g + 1 < e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic fault(input logic p);
        @(posedge core_clk);
        if (p) pos_f <= 1'b1;
        else neg_f <= 1'b1;
        @(posedge core_clk);
        pos_f <= 1'b0;
        neg_f <= 1'b0;
    endtask
    task automatic wait_flag(input logic v);
        for (int i = 0; i < 8 && flag !== v; i++) @(posedge core_clk);
        #1;
        if (flag !== v) begin
            error_cnt++;
            $display("CHECK FAILED flag wait expected %b seen %b", v, flag);
            end_of_test();
        end
    endtask
    task automatic t_regs;
        logic [23:0] d;
        rd(8'h18, d);
        chk("cfg reset", 24'h201800, d);
        wr(8'h20, 24'hffffff);
        rd(8'h20, d);
        chk("unmapped read", 24'h0, d);
        rd(8'h18, d);
        chk("cfg after unmapped write", 24'h201800, d);
        wr(8'h18, 24'h001540);
        rd(8'h1c, d);
        chk("magnitude over limit", 24'h1, 24'(d[11]));
        wr(8'h18, 24'h001530);
        rd(8'h1c, d);
        chk("magnitude within limit", 24'h0, 24'(d[11]));
    endtask
    task automatic t_lowpass;
        logic [23:0] d, w;
        logic [1:0] e;
        for (int k = 0; k < 8; k++) begin
            w = 24'h000810 | (24'(k[2]) << 23) | (24'(k[1:0]) << 12);
            e = (k[2] && k[1:0] == 2'h3) ? 2'h1 : k[1:0];
            wr(8'h18, w);
            rd(8'h18, d);
            chk("lowpass readback", {w[23:14], e, w[11:0]}, d);
            settle();
            chk("lowpass eff", 24'(e), 24'(lpf));
            chk("lowpass bypass", 24'(e == 2'h0), 24'(byp));
        end
    endtask
    task automatic t_codes;
        for (int k = 0; k < 16; k++) begin
            wr(8'h18, 24'h001010 | (24'(k) << 8));
            settle();
            chk("pulse edge ok", 24'(k == 1 || k == 2), 24'(pace_ok));
        end
        for (int m = 0; m < 8; m++) begin
            wr(8'h18, 24'h001000 | (24'(m) << 4));
            settle();
            chk("drive level", (m == 6) ? 24'h0 : 24'(m), 24'(lvl));
        end
    endtask
    task automatic t_monitor;
        logic [23:0] d;
        wr(8'h18, 24'h001891);
        settle();
        rd(8'h1c, d);
        chk("monitor active", 24'h1, 24'(d[1]));
        for (int k = 0; k < 2; k++) begin
            fault(k[0]);
            wait_flag(1'b1);
            rd(8'h1c, d);
            chk("status flag", 24'h1, 24'(d[0]));
            wr(8'h1c, 24'h1);
            wait_flag(1'b0);
        end
        wr(8'h18, 24'h001811);
        settle();
        fault(1'b0);
        settle();
        chk("flag with monitor off", 24'h0, 24'(flag));
        wr(8'h18, 24'h001891);
        chan_on <= 1'b0;
        settle();
        fault(1'b1);
        settle();
        chk("flag with channel off", 24'h0, 24'(flag));
        chan_on <= 1'b1;
    endtask
    task automatic t_phase;
        logic [3:0] code[4] = '{4'h0, 4'h1, 4'h2, 4'h2};
        logic [3:0] ph[4] = '{4'h7, 4'h5, 4'h5, 4'hf};
        int f[4] = '{16, 16, 20, 60};
        int n, m, r;
        logic prev;
        for (int k = 0; k < 4; k++) begin
            wr(8'h18, {12'h001, code[k], 4'h1, ph[k]});
            settle();
            n = 0;
            m = 0;
            r = 0;
            prev = p_out;
            for (int i = 0; i < 5000 && r < 17; i++) begin
                @(posedge core_clk);
                #1;
                if (p_out && !prev) r++;
                prev = p_out;
                if (r > 0 && r < 17) begin
                    n++;
                    if (dref !== p_out) m++;
                end
            end
            if (r < 17) begin
                error_cnt++;
                $display("CHECK FAILED drive period wait expected 17 seen %0d", r);
                end_of_test();
            end
            near("ref phase", f[k], m * 64 / n);
        end
    endtask
    task automatic t_freq;
        logic [1:0] sel[7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h0};
        logic [3:0] code[7] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h0, 4'h4, 4'h5};
        int f[7] = '{131072, 81920, 80000, 18204, 127872, 8192, 4096};
        int fm[4] = '{32768, 32000, 32000, 31968};
        int e, t;
        logic prev;
        for (int k = 0; k < 7; k++) begin
            mclk_sel <= sel[k];
            wr(8'h18, {12'h001, code[k], 8'h10});
            settle();
            e = 0;
            t = 0;
            prev = p_out;
            for (int i = 0; i < 10000; i++) begin
                @(posedge core_clk);
                #1;
                if (p_out && !prev) e++;
                prev = p_out;
                if (tick) t++;
            end
            chk("drive enabled", 24'h1, 24'(p_oe));
            near("drive edges", f[k] / 1000, e);
            near("master ticks", fm[sel[k]] / 1000, t);
        end
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_lowpass();
        t_codes();
        t_phase();
        t_monitor();
        t_freq();
        end_of_test();
    end
endmodule // idf_top_tb_top
